// File: shared/iav_pkg.sv
// shared constants, state encoding and carrier types for interrupt entry and vectoring
package iav_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS = 50;            // ref clock period, 20 mhz
  localparam int ACK_NS = 200;           // least width of each acknowledge pulse
  localparam int ACK_CYC = (ACK_NS + CLK_NS - 1) / CLK_NS; // rounded up to whole cycles
  localparam int GAP_CYC = 1;            // idle cycles between the two acknowledges

  // ****************************************
  // widths, vectors and field positions
  // ****************************************
  localparam int NUM_LEVELS = 8;         // request inputs of one controller
  localparam int LVL_W = 3;              // binary level and cascade code width
  localparam int ADDR_W = 20;            // call address width
  localparam int FLAGS_W = 16;           // processor flags word
  localparam int IE_BIT = 9;             // interrupt enable flag position
  localparam int VEC_SHIFT = 2;          // identifier times four
  localparam logic [ADDR_W-1:0] NMI_VECTOR = 20'h0_0008; // fixed non-maskable vector
  localparam logic [FLAGS_W-1:0] FLAGS_RST = 16'h0000;  // flags after reset, ie clear
  localparam logic [2:0] CNT_ZERO = 3'h0;

  // ****************************************
  // state machine of the entry sequencer
  // ****************************************
  typedef enum logic [2:0] {
    IAV_IDLE,
    IAV_ACK1,
    IAV_GAP,
    IAV_ACK2,
    IAV_PUSH,
    IAV_CALL
  } iav_state_t;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic instr_boundary;                // pulse: current instruction completes
    logic return_from_handler;                          // pulse: return from handler executes
    logic clear_ie;                      // pulse: clear enable op
    logic set_ie;                        // pulse: set enable op
    logic [FLAGS_W-1:0] popped_flags;    // flags popped by the return
  } iav_core_in_t;

  typedef struct packed {
    logic push_valid;                    // pulse: push flags to stack
    logic [FLAGS_W-1:0] push_flags;      // flags to push
    logic call_valid;                    // pulse: indirect call
    logic [ADDR_W-1:0] call_addr;        // vector location to call through
  } iav_entry_t;

endpackage

// File: design/iav_pic.sv
// one priority interrupt controller, master or slave by parameter
`timescale 1ns/1ns
module iav_pic #(
  parameter bit IS_SLAVE = 1'b0,
  parameter int LEVELS = iav_pkg::NUM_LEVELS
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [iav_pkg::NUM_LEVELS-1:0] request_input_i,
  input wire logic [7:0] vector_base_init_word_i,
  input wire logic [7:0] cascade_init_word_i,
  input wire logic ack1_i,
  input wire logic ack2_i,
  input wire logic [iav_pkg::LVL_W-1:0] cascade_i,
  output logic maskable_request_o,
  output logic [iav_pkg::LVL_W-1:0] cascade_o,
  output logic cascade_oe_o,
  output logic [7:0] data_o,
  output logic data_oe_o
);
  import iav_pkg::*;

  // the level encoder below is built for exactly eight inputs
  if (LEVELS != NUM_LEVELS) begin : g_bad_levels
    $error("iav_pic serves eight request inputs only");
  end

  // ****************************************
  // priority: input zero ranks highest
  // ****************************************
  function automatic logic [LVL_W-1:0] first_level(input logic [NUM_LEVELS-1:0] req);
    logic [LVL_W-1:0] lvl;
    lvl = '0;
    for (int i = NUM_LEVELS - 1; i >= 0; i--) begin
      if (req[i]) begin
        lvl = LVL_W'(i);
      end
    end
    return lvl;
  endfunction

  logic [LVL_W-1:0] win_lvl;             // winning level now
  logic win_slaved;                      // winner is a cascaded slave
  logic [LVL_W-1:0] lvl_q;               // level frozen at first acknowledge
  logic slaved_q;                        // frozen slaved flag
  logic casc_act_q;                      // cascade code being broadcast
  logic ack2_q;                          // ack2 delayed, for end detect
  logic selected;                        // this controller answers ack2

  assign win_lvl = first_level(request_input_i);
  assign win_slaved = !IS_SLAVE && cascade_init_word_i[win_lvl];
  assign maskable_request_o = |request_input_i;
  // slave answers only when the broadcast code names its identity
  assign selected = IS_SLAVE ? (cascade_i == cascade_init_word_i[LVL_W-1:0])
                             : !slaved_q;
  assign data_oe_o = ack2_i && selected;
  assign cascade_o = lvl_q;
  assign cascade_oe_o = casc_act_q;

  // freeze the winner on the first acknowledge and form the identifier
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lvl_q <= '0;
      slaved_q <= 1'b0;
      data_o <= 8'h00;
    end else if (ack1_i) begin
      lvl_q <= win_lvl;
      slaved_q <= win_slaved;
      data_o <= vector_base_init_word_i + 8'(win_lvl);
    end
  end

  // cascade code stands from first acknowledge until second ends
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      casc_act_q <= 1'b0;
      ack2_q <= 1'b0;
    end else begin
      ack2_q <= ack2_i;
      if (ack1_i && win_slaved) begin
        casc_act_q <= 1'b1;
      end else if (ack2_q && !ack2_i) begin
        casc_act_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  master_own_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (data_oe_o && !IS_SLAVE) |-> !slaved_q)
    else $error("master answered for a slaved level");
  vector_form_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $rose(data_oe_o) |-> data_o == vector_base_init_word_i + 8'(lvl_q))
    else $error("identifier is not base plus level");
  cascade_code_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (ack1_i && win_slaved) |=> cascade_oe_o && cascade_o == $past(win_lvl))
    else $error("cascade code not broadcast on first acknowledge");
endmodule

// File: design/iav_interrupt_ack_vectoring.sv
// processor interrupt entry sequencer with on-board master controller
`timescale 1ns/1ns

module iav_interrupt_ack_vectoring (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic nmi_pin_i,
  input wire logic [iav_pkg::NUM_LEVELS-1:0] request_input_i,
  input wire iav_pkg::iav_core_in_t core_i,
  input wire logic [7:0] vector_base_init_word_i,
  input wire logic [7:0] cascade_init_word_i,
  input wire logic [7:0] data_bus_i,
  output iav_pkg::iav_entry_t entry_o,
  output logic int_enable_o,
  output logic maskable_request_o,
  output logic ack_n_o,
  output logic [iav_pkg::LVL_W-1:0] cascade_o,
  output logic cascade_oe_o,
  output logic [7:0] data_bus_o,
  output logic data_bus_oe_o
);
  import iav_pkg::*;

  // counter is three bits wide
  if (ACK_CYC < 1 || ACK_CYC > 7) begin : g_bad_ack
    $error("acknowledge width does not fit the counter");
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] nmi_sync_q;                // two-stage nmi
  logic nmi_prev_q;                      // for rising edge
  logic [NUM_LEVELS-1:0] req_meta_q;     // first stage of requests
  logic [NUM_LEVELS-1:0] req_sync_q;     // requests usable by logic
  logic [7:0] bus_meta_q;                // first stage of data bus
  logic [7:0] bus_sync_q;                // data bus usable by logic

  // only the second stages and nmi_prev_q are read beyond this process
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      nmi_sync_q <= 2'b00;
      nmi_prev_q <= 1'b0;
      req_meta_q <= '0;
      req_sync_q <= '0;
      bus_meta_q <= 8'h00;
      bus_sync_q <= 8'h00;
    end else begin
      nmi_sync_q <= {nmi_sync_q[0], nmi_pin_i};
      nmi_prev_q <= nmi_sync_q[1];
      req_meta_q <= request_input_i;
      req_sync_q <= req_meta_q;
      bus_meta_q <= data_bus_i;
      bus_sync_q <= bus_meta_q;
    end
  end

  // ****************************************
  // state and decode
  // ****************************************
  iav_state_t state_q;                   // entry sequencer state
  iav_state_t state_d;
  logic [2:0] cnt_q;                     // cycles within an acknowledge
  logic nmi_pend_q;                      // latched nmi edge
  logic nmi_q;                           // entry in progress is nmi
  logic [FLAGS_W-1:0] flags_q;           // processor flags
  logic [7:0] id_q;                      // identifier from the bus
  logic nmi_edge;
  logic take_nmi;
  logic take_int;
  logic ack_last;
  logic ack1_w;
  logic ack2_w;
  logic pic_oe;
  logic [7:0] pic_data;
  logic [7:0] id_sel;

  assign nmi_edge = nmi_sync_q[1] && !nmi_prev_q;
  // nmi wins whenever both are pending at the boundary
  assign take_nmi = state_q == IAV_IDLE && core_i.instr_boundary && nmi_pend_q;
  assign take_int = state_q == IAV_IDLE && core_i.instr_boundary && !nmi_pend_q
                    && maskable_request_o && flags_q[IE_BIT];
  assign ack_last = cnt_q == 3'(ACK_CYC - 1);
  assign ack1_w = state_q == IAV_ACK1;
  assign ack2_w = state_q == IAV_ACK2;
  assign ack_n_o = !(ack1_w || ack2_w);
  assign int_enable_o = flags_q[IE_BIT];
  // own controller's byte if it answers, otherwise a slave's on the bus
  assign id_sel = pic_oe ? pic_data : bus_sync_q;
  assign data_bus_o = pic_data;
  assign data_bus_oe_o = pic_oe;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      IAV_IDLE: begin
        if (take_nmi) begin
          state_d = IAV_PUSH;
        end else if (take_int) begin
          state_d = IAV_ACK1;
        end
      end
      IAV_ACK1: begin
        if (ack_last) begin
          state_d = IAV_GAP;
        end
      end
      IAV_GAP: begin
        if (cnt_q == 3'(GAP_CYC - 1)) begin
          state_d = IAV_ACK2;
        end
      end
      IAV_ACK2: begin
        if (ack_last) begin
          state_d = IAV_PUSH;
        end
      end
      IAV_PUSH: state_d = IAV_CALL;
      IAV_CALL: state_d = IAV_IDLE;
    endcase
  end

  // state register and per-phase counter
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= IAV_IDLE;
      cnt_q <= CNT_ZERO;
    end else begin
      state_q <= state_d;
      cnt_q <= (state_d != state_q) ? CNT_ZERO : cnt_q + 3'h1;
    end
  end

  // nmi edge held until taken; a new edge in the taking cycle survives
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      nmi_pend_q <= 1'b0;
      nmi_q <= 1'b0;
    end else begin
      nmi_pend_q <= nmi_edge || (nmi_pend_q && !take_nmi);
      if (take_nmi || take_int) begin
        nmi_q <= take_nmi;
      end
    end
  end

  // identifier sampled at the end of the second acknowledge
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      id_q <= 8'h00;
    end else if (ack2_w && ack_last) begin
      id_q <= id_sel;
    end
  end

  // flags: entry clears enable, return restores, core ops set or clear
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flags_q <= FLAGS_RST;
    end else if (state_q == IAV_PUSH) begin
      flags_q[IE_BIT] <= 1'b0;
    end else if (core_i.return_from_handler) begin
      flags_q <= core_i.popped_flags;
    end else if (core_i.clear_ie) begin
      flags_q[IE_BIT] <= 1'b0;
    end else if (core_i.set_ie) begin
      flags_q[IE_BIT] <= 1'b1;
    end
  end

  // ****************************************
  // entry outputs, registered
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      entry_o <= '0;
    end else begin
      entry_o.push_valid <= state_q == IAV_PUSH;
      entry_o.call_valid <= state_q == IAV_CALL;
      if (state_q == IAV_PUSH) begin
        entry_o.push_flags <= flags_q;
      end
      if (state_q == IAV_CALL) begin
        // fixed vector for nmi, else identifier times four
        entry_o.call_addr <= nmi_q ? NMI_VECTOR
                                   : ADDR_W'({id_q, 2'b00});
      end
    end
  end

  // ****************************************
  // on-board master controller
  // ****************************************
  iav_pic #(
    .IS_SLAVE(1'b0),
    .LEVELS(NUM_LEVELS)
  ) u_master (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .request_input_i(req_sync_q),
    .vector_base_init_word_i(vector_base_init_word_i),
    .cascade_init_word_i(cascade_init_word_i),
    .ack1_i(ack1_w && cnt_q == CNT_ZERO),
    .ack2_i(ack2_w),
    .cascade_i(3'h0),
    .maskable_request_o(maskable_request_o),
    .cascade_o(cascade_o),
    .cascade_oe_o(cascade_oe_o),
    .data_o(pic_data),
    .data_oe_o(pic_oe)
  );

  // ****************************************
  // checks
  // ****************************************
  nmi_first_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (state_q == IAV_IDLE && core_i.instr_boundary && nmi_pend_q) |=> state_q == IAV_PUSH)
    else $error("pending nmi not taken first");
  boundary_only_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (state_q == IAV_IDLE && !core_i.instr_boundary) |=> state_q == IAV_IDLE)
    else $error("entry started off a boundary");
  nmi_vector_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (entry_o.call_valid && nmi_q) |-> entry_o.call_addr == NMI_VECTOR && !int_enable_o)
    else $error("nmi call not through fixed vector");
  enable_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (state_q == IAV_IDLE && !nmi_pend_q && !flags_q[IE_BIT]) |=> state_q != IAV_ACK1)
    else $error("maskable request taken while disabled");
  two_acks_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ($fell(ack_n_o) && ack1_w) |-> (!ack_n_o)[*4] ##1 ack_n_o ##1 (!ack_n_o)[*4] ##1 ack_n_o)
    else $error("acknowledge pair malformed");
  push_clears_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (ack2_w && ack_last) |=> ##1 entry_o.push_valid && !int_enable_o ##1 entry_o.call_valid)
    else $error("flags not pushed and enable not cleared");
  call_times4_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (entry_o.call_valid && !nmi_q) |-> entry_o.call_addr == {10'h000, id_q, 2'b00})
    else $error("call address is not identifier times four");
  return_from_handler_restore_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (core_i.return_from_handler && state_q != IAV_PUSH) |=> flags_q == $past(core_i.popped_flags))
    else $error("return did not restore flags");

  nmi_entry_c: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    entry_o.call_valid && nmi_q);
  master_entry_c: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ack2_w && pic_oe);
  slave_entry_c: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ack2_w && cascade_oe_o && !pic_oe);
  return_from_handler_c: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) core_i.return_from_handler);
endmodule

// File: bench/iav_slave_model.sv
// behavioural cascaded slave controller on the far side of the master
`timescale 1ns/1ns
module iav_slave_model (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic ack_n_i,
  input wire logic [2:0] cascade_i,
  input wire logic cascade_oe_i,
  input wire logic [2:0] identity_i,
  input wire logic [7:0] base_i,
  input wire logic [7:0] req_i,
  output logic master_req_o,
  output logic [7:0] data_o
);
  import iav_pkg::*;
  // ****************************************
  // state
  // ****************************************
  logic ack_q; // acknowledge level one cycle ago
  logic done1_q; // first acknowledge of this entry is over
  logic sel_q; // cascade code named our identity
  logic [7:0] last_q; // last value we drove on the bus
  logic [2:0] lvl_w; // highest priority pending level, 0 first
  logic drive_w; // we own the bus now
  logic rise_w; // an acknowledge pulse ends
  // any pending level pulls our master input
  assign master_req_o = |req_i;
  always_comb begin
    lvl_w = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (req_i[i]) begin
        lvl_w = 3'(i);
      end
    end
  end
  assign rise_w = !ack_q && ack_n_i;
  // answer from the very first cycle of the second acknowledge
  assign drive_w = !ack_n_i && done1_q && sel_q;
  // no pull on this bus: a released line shows the inverse of its last value
  assign data_o = drive_w ? base_i + {5'h00, lvl_w} : ~last_q;
  // acknowledge tracking; the code is only taken inside the first pulse
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_q <= 1'b1;
      done1_q <= 1'b0;
      sel_q <= 1'b0;
      last_q <= 8'h00;
    end else begin
      ack_q <= ack_n_i;
      // remember only what we drove, so a released line holds one steady level
      if (drive_w) begin
        last_q <= data_o;
      end
      if (rise_w) begin
        done1_q <= !done1_q;
      end
      if (cascade_oe_i && !ack_n_i && !done1_q) begin
        sel_q <= cascade_i == identity_i;
      end else if (rise_w && done1_q) begin
        sel_q <= 1'b0;
      end
    end
  end
endmodule

// File: bench/iav_interrupt_ack_vectoring_bench.sv
// self-checking bench for interrupt entry and vectoring
`timescale 1ns/1ns
module iav_interrupt_ack_vectoring_bench;
  import iav_pkg::*;
  // ****************************************
  // stimulus and observation
  // ****************************************
  localparam logic [2:0] SLV = 3'h3; // master level with the slave behind it
  localparam logic [FLAGS_W-1:0] IE_FL = 16'h0001 << IE_BIT; // only ie set
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic nmi = 1'b0;
  logic [7:0] own_req = 8'h00; // levels wired straight to the master
  logic [7:0] slv_req = 8'h00; // levels pending inside the slave
  logic [7:0] base = 8'hfa; // high levels wrap past 8 bits
  logic [7:0] casc_cfg = 8'h08; // only level 3 is slaved
  iav_core_in_t core = '0;
  iav_entry_t entry;
  logic int_enable_o, maskable_request_o, ack_n_o, cascade_oe_o, data_bus_oe_o;
  logic [2:0] cascade_o;
  logic [7:0] data_bus_o, slv_data, bus_w, req_w;
  logic slv_mreq;
  int error_cnt = 0;
  int samples_checked = 0;
  int n_ack, push_i, call_i; // what one entry looked like
  logic saw_doe, saw_coe;
  logic [7:0] bus_seen; // identifier the master put on the bus
  logic [2:0] casc_seen;
  logic [15:0] push_fl;
  logic [19:0] call_ad;
  // shared data wire: master drives only with its enable up
  assign bus_w = data_bus_oe_o ? data_bus_o : slv_data;
  assign req_w = own_req | ({7'h00, slv_mreq} << SLV);
  iav_interrupt_ack_vectoring u_iav_interrupt_ack_vectoring (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .nmi_pin_i(nmi), .request_input_i(req_w),
    .core_i(core), .vector_base_init_word_i(base), .cascade_init_word_i(casc_cfg),
    .data_bus_i(bus_w), .entry_o(entry), .int_enable_o(int_enable_o),
    .maskable_request_o(maskable_request_o), .ack_n_o(ack_n_o), .cascade_o(cascade_o),
    .cascade_oe_o(cascade_oe_o), .data_bus_o(data_bus_o), .data_bus_oe_o(data_bus_oe_o));
  iav_slave_model u_iav_slave_model (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ack_n_i(ack_n_o), .cascade_i(cascade_o),
    .cascade_oe_i(cascade_oe_o), .identity_i(SLV), .base_i(8'h90), .req_i(slv_req),
    .master_req_o(slv_mreq), .data_o(slv_data));
  // 20 mhz clock
  initial begin
    forever #25 ref_clk_i = !ref_clk_i;
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic finish_test();
    $display("checked %0d, mismatched %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic set_ie();
    core.set_ie = 1'b1;
    cyc(1);
    core.set_ie = 1'b0;
  endtask
  // one boundary, then record the entry until its call, bounded
  task automatic run_entry();
    logic ack_prev;
    ack_prev = 1'b1;
    n_ack = 0;
    saw_doe = 1'b0;
    saw_coe = 1'b0;
    bus_seen = 8'h00;
    casc_seen = 3'h0;
    push_i = -1;
    call_i = -1;
    core.instr_boundary = 1'b1;
    cyc(1);
    core.instr_boundary = 1'b0;
    for (int i = 0; i < 40 && call_i < 0; i++) begin
      if (ack_n_o === 1'b0 && ack_prev === 1'b1) n_ack++;
      ack_prev = ack_n_o;
      if (data_bus_oe_o === 1'b1) begin
        saw_doe = 1'b1;
        bus_seen = data_bus_o;
      end
      if (cascade_oe_o === 1'b1) begin
        saw_coe = 1'b1;
        casc_seen = cascade_o;
      end
      if (entry.push_valid === 1'b1) begin
        push_i = i;
        push_fl = entry.push_flags;
      end
      if (entry.call_valid === 1'b1) begin
        call_i = i;
        call_ad = entry.call_addr;
      end
      cyc(1);
    end
    if (call_i < 0) begin
      chk(1'b0, 1'b1); // hung entry
      finish_test();
    end
  endtask
  // no acknowledge and no push over n cycles
  task automatic watch_quiet(input int n, input logic bnd);
    logic busy;
    busy = 1'b0;
    core.instr_boundary = bnd;
    cyc(1);
    core.instr_boundary = 1'b0;
    repeat (n) begin
      if (ack_n_o !== 1'b1 || entry.push_valid !== 1'b0) busy = 1'b1;
      cyc(1);
    end
    chk(busy, 1'b0);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    chk({ack_n_o, int_enable_o, cascade_oe_o, data_bus_oe_o}, 4'h8);
    chk(entry, '0);
    $display("test reset done");
  endtask
  // pending request held off by a clear flag, then by a missing boundary
  task automatic t_gate();
    own_req = 8'h20;
    cyc(3);
    chk(maskable_request_o, 1'b1);
    watch_quiet(20, 1'b1);
    set_ie();
    chk(int_enable_o, 1'b1);
    core.clear_ie = 1'b1;
    cyc(1);
    core.clear_ie = 1'b0;
    chk(int_enable_o, 1'b0);
    watch_quiet(10, 1'b1);
    set_ie();
    watch_quiet(20, 1'b0);
    own_req = 8'h00;
    cyc(3);
    $display("test gate done");
  endtask
  // every direct level, level 7 also pending underneath, base wraps
  task automatic t_master();
    for (int l = 0; l < NUM_LEVELS; l++) begin
      if (l != SLV) begin
        own_req = 8'h80 | (8'h01 << l);
        set_ie();
        cyc(3);
        run_entry();
        chk(n_ack, 2);
        chk({saw_doe, saw_coe}, 2'b10);
        chk(bus_seen, 8'(base + l));
        chk(push_fl, IE_FL);
        chk(int_enable_o, 1'b0);
        chk(call_i - push_i, 1);
        chk(call_ad, {10'h000, 8'(base + l), 2'b00});
        own_req = 8'h00;
        cyc(3);
      end
    end
    $display("test master done");
  endtask
  // slave at level 3 answers with its own base plus level 2
  task automatic t_slave();
    slv_req = 8'h44;
    set_ie();
    cyc(4);
    run_entry();
    chk(n_ack, 2);
    chk({saw_coe, casc_seen}, {1'b1, SLV});
    chk(saw_doe, 1'b0);
    chk(call_ad, {10'h000, 8'h92, 2'b00});
    slv_req = 8'h00;
    cyc(4);
    $display("test slave done");
  endtask
  // nmi beats an enabled maskable request, return restores, maskable follows
  task automatic t_nmi();
    own_req = 8'h01;
    set_ie();
    nmi = 1'b1;
    cyc(4);
    run_entry();
    chk(n_ack, 0);
    chk(call_ad, NMI_VECTOR);
    chk(push_fl, IE_FL);
    chk(int_enable_o, 1'b0);
    chk(call_i - push_i, 1);
    nmi = 1'b0;
    core.return_from_handler = 1'b1;
    core.popped_flags = IE_FL;
    cyc(1);
    core.return_from_handler = 1'b0;
    core.popped_flags = '0;
    chk(int_enable_o, 1'b1);
    run_entry();
    chk(n_ack, 2);
    chk(call_ad, {10'h000, base, 2'b00});
    chk(bus_seen, base);
    own_req = 8'h00;
    cyc(3);
    $display("test nmi done");
  endtask
  // main sequence: reset two cycles, then each scenario
  initial begin
    cyc(1);
    t_reset();
    cyc(1);
    rstn_i = 1'b1;
    cyc(2);
    t_gate();
    t_master();
    t_slave();
    t_nmi();
    finish_test();
  end
endmodule
